// [src/nand_host_cfg.svh]
// Opcodes, address layout and strobe timing for the NAND host controller.
// Assumes a 200 MHz ref_clk and a die on the asynchronous 8-bit bus.
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

`define CMD_READ_SETUP 8'h00
`define CMD_READ_CONFIRM 8'h30
`define CMD_CACHE_RANDOM_CONF 8'h31
`define CMD_CACHE_SEQ 8'h31
`define CMD_CACHE_LAST 8'h3F
`define CMD_READ_STATUS 8'h70
`define CMD_RESET 8'hFF

`define FULL_ADDR_CYCLES 3'h5
`define COL_TOP_POS 11
`define PLANE_BIT_POS 6

`define CLK_MHZ 200
`define STROBE_NS 15
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define BUSY_SETTLE_NS 100
`define BUSY_SETTLE_CYC ((`BUSY_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define TIMER_W 6

`define FIFO_DEPTH 8
`define FIFO_WIDTH 8

`endif

// [src/nand_host_pkg.sv]
// Types shared by the NAND host controller and its user.
// Assumes nand_host_cfg.svh is on the include path.
`include "nand_host_cfg.svh"

package nand_host_pkg;

   typedef enum logic [2:0] {
      OP_RESET = 3'h0,
      OP_READ_PAGE = 3'h1,
      OP_CACHE_SEQ = 3'h2,
      OP_CACHE_RANDOM = 3'h3,
      OP_CACHE_LAST = 3'h4,
      OP_READ_STATUS = 3'h5
   } op_kind_e;

   typedef struct packed {
      op_kind_e kind;
      logic [11:0] column;
      logic [5:0] page;
      logic [10:0] block;
      logic [11:0] read_len;
   } req_s;

   typedef struct packed {
      logic [7:0] first;
      logic [2:0] naddr;
      logic has_conf;
      logic [7:0] conf;
      logic need_ready;
      logic wait_busy;
   } op_plan_s;

   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic [7:0] io_out;
      logic io_oe;
   } nand_pins_s;

endpackage

// [src/byte_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_st_s;

   fifo_st_s st_reg;
   fifo_st_s st_next;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
         $error("byte_fifo: DEPTH must be a power of two >= 2");
      end
   endgenerate

   assign in_ready = st_reg.cnt != (AW + 1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data = st_reg.mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   fifo_full_a: assert property (@(posedge ref_clk) disable iff (rst)
      !in_ready |-> st_reg.cnt == (AW + 1)'(DEPTH) && st_reg.wr == st_reg.rd)
      else $error("fifo full flag wrong");
endmodule // byte_fifo

// [src/nand_host_ctrl.sv]
// Host controller driving an asynchronous 8-bit NAND die over its pins.
// Assumes the die on the far side of the pins; pins are asynchronous to ref_clk.
//
// Behaviour
// - Full address: two column bytes, page plus two low block bits, two block bytes.
// - Command, address and data share one bus; latch selects tell them apart.
// - Random cache read is 00h, five address bytes, 31h, never while busy.
// - Cache read ends with lone command 3Fh, no address bytes.
// - A command byte is taken at the write strobe rise with command latch high.
// - An address byte is taken at the write strobe rise with address latch high.
`timescale 1ns/1ps

module nand_host_ctrl
   import nand_host_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire req_s req,
   output logic done,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   output nand_pins_s pins,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_WAIT_RDY = 3'b001,
      S_CMD = 3'b011,
      S_ADDR = 3'b010,
      S_CONF = 3'b110,
      S_WAIT_BUSY = 3'b111,
      S_READ = 3'b101,
      S_DONE = 3'b100
   } state_e;

   typedef struct packed {
      state_e state;
      logic ph;
      logic [`TIMER_W-1:0] cnt;
      logic [2:0] idx;
      logic [11:0] rd_left;
      req_s req;
      op_plan_s plan;
      nand_pins_s pins;
      logic rb_meta;
      logic rb_sync;
      logic [7:0] io_meta;
      logic [7:0] io_sync;
   } ctrl_st_s;

   localparam logic [`TIMER_W-1:0] STROBE_LOAD = `TIMER_W'(`STROBE_CYC - 1);
   localparam logic [`TIMER_W-1:0] SETTLE_LOAD = `TIMER_W'(`BUSY_SETTLE_CYC - 1);
   // Cycles from read strobe fall to the push of its byte
   localparam int READ_PUSH_DLY = `STROBE_CYC - 1;
   localparam nand_pins_s PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
      read_strobe_n: 1'b1, io_out: 8'h00, io_oe: 1'b0};
   localparam ctrl_st_s RESET_ST = '{state: S_IDLE, ph: 1'b0, cnt: '0, idx: 3'h0,
      rd_left: 12'h000, req: '0, plan: '0, pins: PINS_IDLE, rb_meta: 1'b0,
      rb_sync: 1'b0, io_meta: 8'h00, io_sync: 8'h00};

   generate
      if (`STROBE_CYC < 1 || `BUSY_SETTLE_CYC >= (1 << `TIMER_W) || FIFO_DEPTH < 2)
      begin : g_bad
         $error("nand_host_ctrl: timing or depth out of range");
      end
   endgenerate

   ctrl_st_s st_reg;
   ctrl_st_s st_next;
   logic push;
   logic fifo_in_ready;
   logic adv;
   state_e tgt;

   function automatic op_plan_s plan_of(op_kind_e k);
      op_plan_s p;
      p = '{first: `CMD_RESET, naddr: 3'h0, has_conf: 1'b0, conf: 8'h00,
         need_ready: 1'b0, wait_busy: 1'b1};
      case (k)
         OP_READ_PAGE: begin
            p = '{`CMD_READ_SETUP, `FULL_ADDR_CYCLES, 1'b1, `CMD_READ_CONFIRM, 1'b1, 1'b1};
         end
         OP_CACHE_RANDOM: begin
            p = '{`CMD_READ_SETUP, `FULL_ADDR_CYCLES, 1'b1, `CMD_CACHE_RANDOM_CONF,
               1'b1, 1'b1};
         end
         OP_CACHE_SEQ: begin
            p = '{`CMD_CACHE_SEQ, 3'h0, 1'b0, 8'h00, 1'b1, 1'b1};
         end
         OP_CACHE_LAST: begin
            p = '{`CMD_CACHE_LAST, 3'h0, 1'b0, 8'h00, 1'b1, 1'b1};
         end
         OP_READ_STATUS: begin
            p = '{`CMD_READ_STATUS, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0};
         end
         default: begin
            p.first = `CMD_RESET;
         end
      endcase
      return p;
   endfunction

   function automatic logic [7:0] addr_byte(req_s r, logic [2:0] i);
      logic [11:0] c;
      logic [7:0] b;
      c = r.column;
      if (c[`COL_TOP_POS]) begin
         c[10:7] = 4'h0;
      end
      case (i)
         3'h0: b = c[7:0];
         3'h1: b = {4'h0, c[11:8]};
         3'h2: b = {r.block[1:0], r.page};
         3'h3: b = r.block[9:2];
         default: b = {7'h00, r.block[10]};
      endcase
      return b;
   endfunction

   assign req_ready = st_reg.state == S_IDLE;
   assign done = st_reg.state == S_DONE;
   assign pins = st_reg.pins;
   // Byte taken at end of read strobe low
   assign push = st_reg.state == S_READ && !st_reg.pins.read_strobe_n && st_reg.cnt == '0;

   always_comb begin
      st_next = st_reg;
      adv = 1'b0;
      tgt = st_reg.state;
      st_next.rb_meta = ready_busy_n;
      st_next.rb_sync = st_reg.rb_meta;
      st_next.io_meta = io_in;
      st_next.io_sync = st_reg.io_meta;
      case (st_reg.state)
         S_IDLE: begin
            if (req_valid) begin
               st_next.req = req;
               st_next.plan = plan_of(req.kind);
               st_next.rd_left = req.read_len;
               st_next.state = S_WAIT_RDY;
            end
         end
         S_WAIT_RDY: begin
            if (!st_reg.plan.need_ready || st_reg.rb_sync) begin
               adv = 1'b1;
               tgt = S_CMD;
            end
         end
         S_CMD, S_ADDR, S_CONF: begin
            if (st_reg.cnt != '0) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (!st_reg.ph) begin
               st_next.pins.we_n = 1'b1;
               st_next.ph = 1'b1;
               st_next.cnt = STROBE_LOAD;
            end else begin
               adv = 1'b1;
               if (st_reg.state == S_CMD && st_reg.plan.naddr != 3'h0) begin
                  tgt = S_ADDR;
                  st_next.idx = 3'h0;
               end else if (st_reg.state == S_ADDR && st_reg.idx + 3'h1 < st_reg.plan.naddr)
               begin
                  tgt = S_ADDR;
                  st_next.idx = st_reg.idx + 3'h1;
               end else if (st_reg.state != S_CONF && st_reg.plan.has_conf) begin
                  tgt = S_CONF;
               end else if (st_reg.plan.wait_busy) begin
                  tgt = S_WAIT_BUSY;
               end else begin
                  tgt = S_READ;
               end
            end
         end
         S_WAIT_BUSY: begin
            if (st_reg.cnt != '0) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (st_reg.rb_sync) begin
               st_next.state = S_READ;
            end
         end
         S_READ: begin
            if (st_reg.cnt != '0) begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end else if (!st_reg.pins.read_strobe_n) begin
               st_next.pins.read_strobe_n = 1'b1;
               st_next.cnt = STROBE_LOAD;
               st_next.rd_left = st_reg.rd_left - 12'h001;
            end else if (st_reg.rd_left == 12'h000) begin
               st_next.state = S_DONE;
            end else if (fifo_in_ready) begin
               st_next.pins.read_strobe_n = 1'b0;
               st_next.cnt = STROBE_LOAD;
            end
         end
         default: begin
            st_next.state = S_IDLE;
         end
      endcase
      if (adv) begin
         st_next.state = tgt;
         st_next.ph = 1'b0;
         st_next.cnt = STROBE_LOAD;
         st_next.pins.cle = tgt == S_CMD || tgt == S_CONF;
         st_next.pins.ale = tgt == S_ADDR;
         st_next.pins.we_n = !(tgt == S_CMD || tgt == S_CONF || tgt == S_ADDR);
         st_next.pins.io_oe = !st_next.pins.we_n;
         if (tgt == S_CMD) begin
            st_next.pins.io_out = st_reg.plan.first;
         end else if (tgt == S_CONF) begin
            st_next.pins.io_out = st_reg.plan.conf;
         end else if (tgt == S_ADDR) begin
            st_next.pins.io_out = addr_byte(st_reg.req, st_next.idx);
         end else begin
            st_next.pins.io_out = 8'h00;
         end
         if (tgt == S_WAIT_BUSY) begin
            st_next.cnt = SETTLE_LOAD;
         end else if (tgt == S_READ) begin
            st_next.cnt = '0;
         end
      end
      st_next.pins.ce_n = st_next.state == S_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= RESET_ST;
      end else begin
         st_reg <= st_next;
      end
   end

   byte_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(st_reg.io_sync),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   latch_exclusive_a: assert property (@(posedge ref_clk) disable iff (rst)
      !(pins.cle && pins.ale))
      else $error("command and address latch both high");

   cmd_latch_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(pins.we_n) |-> pins.io_oe && $stable(pins.io_out) && (pins.cle ^ pins.ale))
      else $error("write strobe rose without stable selected byte");

   addr_latch_type_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(pins.we_n) && st_reg.state == S_ADDR |-> pins.ale && !pins.cle)
      else $error("address byte without address latch");

   spare_column_a: assert property (@(posedge ref_clk) disable iff (rst)
      pins.ale && st_reg.idx == 3'h1 && pins.io_out[3] |-> pins.io_out[2:0] == 3'h0)
      else $error("spare column with nonzero middle bits");

   addr_high_low_a: assert property (@(posedge ref_clk) disable iff (rst)
      pins.ale && (st_reg.idx == 3'h1 || st_reg.idx == 3'h4) |->
      pins.io_out[7:4] == 4'h0 && (st_reg.idx != 3'h4 || pins.io_out[3:1] == 3'h0))
      else $error("address byte unused bits not low");

   ready_before_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
      $past(st_reg.state) == S_WAIT_RDY && st_reg.state == S_CMD && st_reg.plan.need_ready
      |-> $past(st_reg.rb_sync))
      else $error("command issued while die busy");

   last_no_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
      st_reg.state == S_CMD && st_reg.req.kind == OP_CACHE_LAST |->
      pins.io_out == `CMD_CACHE_LAST ##1 (st_reg.state != S_ADDR) [*8])
      else $error("cache last sent with address");

   addr_order_a: assert property (@(posedge ref_clk) disable iff (rst)
      $past(st_reg.state) == S_ADDR && st_reg.state == S_ADDR && $changed(st_reg.idx) |->
      st_reg.idx == 3'($past(st_reg.idx) + 3'h1) && st_reg.idx < st_reg.plan.naddr)
      else $error("address bytes out of order");

   read_push_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(pins.read_strobe_n) |-> ##READ_PUSH_DLY push && fifo_in_ready)
      else $error("read byte not pushed on time");
endmodule // nand_host_ctrl

// [bench/nand_die_model.sv]
// Behavioural NAND die on the far side of the host controller pins.
// Assumes one die, always selected by ce_n low; ready line pulled up.
`timescale 1ns/1ps

module nand_die_model
   import nand_host_pkg::*;
(
   input wire nand_pins_s pins,
   input wire logic slow,
   output logic [7:0] io_in,
   output logic ready_busy_n
);
   logic [8:0] log_q [0:63];
   int log_n = 0;
   int rd_cnt = 0;
   int bad = 0;
   int ai = 0;
   logic [7:0] cmd_reg = 8'h00;
   logic [7:0] addr_reg [0:4];
   logic [11:0] col_cnt = 12'h000;
   logic [7:0] status_reg;
   wire we = pins.we_n;
   wire rs = pins.read_strobe_n;
   event go_busy;
   wire [16:0] page_addr = {addr_reg[4][0], addr_reg[3], addr_reg[2]};
   wire plane = addr_reg[2][6];

   initial begin
      io_in = 8'hA5;
      ready_busy_n = 1'b1;
   end

   assign status_reg = ready_busy_n ? 8'hE0 : 8'h80;

   always @(posedge we) begin
      if (!pins.ce_n && pins.cle) begin
         if (pins.io_out != 8'hFF && pins.io_out != 8'h70 && !ready_busy_n) bad++;
         cmd_reg = pins.io_out;
         ai = 0;
         log_q[log_n] = {1'b0, pins.io_out};
         log_n++;
         if (cmd_reg inside {8'h30, 8'h31, 8'h3F, 8'hFF}) begin
            col_cnt = {addr_reg[1][3:0], addr_reg[0]};
            -> go_busy;
         end
      end else if (!pins.ce_n && pins.ale) begin
         addr_reg[ai] = pins.io_out;
         ai++;
         log_q[log_n] = {1'b1, pins.io_out};
         log_n++;
      end
   end

   always begin
      @(go_busy);
      ready_busy_n = 1'b0;
      #(slow ? 2000 : 60);
      ready_busy_n = 1'b1;
   end

   always @(negedge rs) begin
      if (!pins.ce_n) begin
         #2 io_in = (cmd_reg == 8'h70) ? status_reg : col_cnt[7:0] + page_addr[7:0];
         col_cnt++;
         rd_cnt++;
      end
   end

   // Released bus shows inverse of last byte
   always @(posedge rs) #1 io_in = ~io_in;
endmodule // nand_die_model

// [bench/tb_top.sv]
// Self-checking bench for the NAND host controller.
// Assumes nand_die_model on the pins and the design sources compiled first.
`timescale 1ns/1ps

module tb_top;
   import nand_host_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic rd_ready = 1'b0;
   logic slow = 1'b0;
   req_s req = '0;
   logic req_ready, done, rd_valid, ready_busy_n;
   logic [7:0] rd_data, io_in;
   nand_pins_s pins;
   int mismatches = 0;
   int compares = 0;
   logic [7:0] got [$];
   logic [8:0] exp_q [$];

   always #2.5 ref_clk = ~ref_clk;

   nand_host_ctrl #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .done(done), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));

   nand_die_model die (.pins(pins), .slow(slow), .io_in(io_in), .ready_busy_n(ready_busy_n));

   task check(input logic [16:0] seen, input logic [16:0] exp_v);
      compares++;
      if (seen !== exp_v) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp_v);
      end
   endtask

   task results;
      $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task run_op(input req_s r, input int stall);
      int n;
      int s;
      got.delete();
      s = die.rd_cnt;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= r;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      for (n = 0; n < 20000 && !done; n++) begin
         @(posedge ref_clk);
         if (rd_valid && rd_ready) got.push_back(rd_data);
         if (stall > 0 && n == stall) check(die.rd_cnt - s, 8);
         rd_ready <= (n >= stall);
      end
      if (n >= 20000) begin
         mismatches++;
         results();
      end
      for (int i = 0; i < 24; i++) begin
         @(posedge ref_clk);
         if (rd_valid && rd_ready) got.push_back(rd_data);
         rd_ready <= 1'b1;
      end
      check(rd_valid, 1'b0);
      check({req_ready, pins.ce_n, pins.io_oe}, 3'b110);
      check(got.size(), r.read_len);
   endtask

   task chk_log(input int s);
      for (int i = 0; i < exp_q.size(); i++) check(die.log_q[s + i], exp_q[i]);
      check(die.log_n - s, exp_q.size());
   endtask

   task t_single;
      op_kind_e k [4] = '{OP_RESET, OP_CACHE_SEQ, OP_CACHE_LAST, OP_READ_STATUS};
      logic [7:0] op [4] = '{8'hFF, 8'h31, 8'h3F, 8'h70};
      logic [11:0] len [4] = '{12'h000, 12'h002, 12'h001, 12'h001};
      int s;
      for (int i = 0; i < 4; i++) begin
         s = die.log_n;
         run_op('{k[i], 12'h000, 6'h00, 11'h000, len[i]}, 0);
         exp_q = '{{1'b0, op[i]}};
         chk_log(s);
      end
      check(got[0], 8'hE0);
      $display("test single commands finished");
   endtask

   task t_read(input op_kind_e k, input logic [11:0] col, input logic [5:0] pg,
               input logic [10:0] blk, input logic [11:0] len, input int stall,
               input logic [7:0] conf);
      logic [11:0] c;
      int s;
      c = col;
      if (c[11]) c[10:7] = 4'h0;
      s = die.log_n;
      exp_q = '{{1'b0, 8'h00}, {1'b1, c[7:0]}, {1'b1, 4'h0, c[11:8]}, {1'b1, blk[1:0], pg},
                {1'b1, blk[9:2]}, {1'b1, 7'h00, blk[10]}, {1'b0, conf}};
      run_op('{k, col, pg, blk, len}, stall);
      chk_log(s);
      for (int i = 0; i < got.size(); i++) begin
         check(got[i], 8'(8'(c + i) + {blk[1:0], pg}));
      end
      check(die.plane, blk[0]);
      check(die.page_addr, {blk, pg});
      check(die.bad, 0);
      $display("test read kind %0d finished", k);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_single();
      slow <= 1'b1;
      t_read(OP_READ_PAGE, 12'hF85, 6'h2A, 11'h7B3, 12'h00A, 600, 8'h30);
      t_read(OP_CACHE_RANDOM, 12'h7FF, 6'h3F, 11'h400, 12'h003, 0, 8'h31);
      slow <= 1'b0;
      t_read(OP_CACHE_RANDOM, 12'h800, 6'h01, 11'h002, 12'h002, 0, 8'h31);
      results();
   end
endmodule // tb_top
